// >>> hw/eepc_top.sv
// eepc_top: eeprom program/erase control with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - pump clock select 1 uses bus clock, 0 uses rc oscillator.
// - power-down bit disables array; reads then give a fixed filler.
// - erase bits pick byte program, byte, block or bulk erase.
// - reset clears all control register bits.
// - latch bit set captures address and data for programming.
// - latch bit cannot clear while high-voltage enable is set.
// - high voltage only with latch set and a valid array or option byte write.
// - clearing latch and high voltage together clears only high voltage.
// - reset copies option byte into the configuration shadow.
// - permanent protect at 0 locks bytes 8f0 to 8ff.
// - permanent protect, once enabled, returns to disabled only when the shadow reloads from the option byte.
// - a block-protect bit at 1 stops program and erase there.
// - stop removes high voltage but keeps the enable bit.
// - leaving stop with enable set reapplies high voltage.
// - four 128-byte blocks, block-protect bits 0 to 3.
// - each further valid write replaces latched address and data.
// - while latched and not powered down, array reads return the latched data.
// - while latched, control writes are ignored until a valid array or option byte write.
module eepc_top #(
  parameter int PGM_TICKS = 64
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic rc_osc_in,
  input wire logic stop_in,
  output logic hv_on_out,
  output logic pump_bus_clock_out,
  output logic array_power_down_out,
  output logic [1:0] config_out
);
  typedef enum logic {BUS_IDLE, BUS_ANSWER} eepc_bus_type;

  function automatic logic in_array(input logic [11:0] a);
    return (a >= eepc_pkg::ARRAY_BASE) && (a <= eepc_pkg::ARRAY_LAST);
  endfunction

  function automatic logic in_secure(input logic [11:0] a);
    return (a >= eepc_pkg::SECURE_FIRST) && (a <= eepc_pkg::SECURE_LAST);
  endfunction

  // block number of an array index
  function automatic logic [1:0] block_of(input logic [8:0] idx);
    return idx[8:eepc_pkg::BLOCK_SHIFT];
  endfunction

  eepc_arr_if arr ();

  eepc_bus_type bus_state_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] nvopt_reg;
  logic [7:0] shadow_reg;
  logic load_pend_reg;
  logic [8:0] lat_idx_reg;
  logic lat_nv_reg;
  logic [7:0] lat_data_reg;
  logic valid_reg;
  logic blocked_reg;
  logic [31:0] readdata_reg;
  logic [7:0] rd_byte;
  logic [7:0] wdata;
  logic [8:0] addr_idx;
  logic req_take, wr_take, rd_take;
  logic latch, hv, perm_on;
  logic wr_ctrl, ctrl_open;
  logic valid_arr_wr, valid_nv_wr;
  logic [3:0] bp;
  eepc_pkg::eepc_mode_type mode;
  logic prot;
  logic hv_apply;
  logic op_go;
  logic [7:0] nv_result;

  assign wdata = avs_writedata_in[7:0];
  assign addr_idx = 9'(avs_address_in - eepc_pkg::ARRAY_BASE);
  assign req_take = (bus_state_reg == BUS_IDLE)
    && (avs_read_in || avs_write_in);
  assign wr_take = req_take && avs_write_in;
  assign rd_take = req_take && avs_read_in;
  assign latch = ctrl_reg[eepc_pkg::CTRL_LATCH];
  assign hv = ctrl_reg[eepc_pkg::CTRL_HV];
  assign perm_on = ~shadow_reg[eepc_pkg::OPT_PERM];
  assign bp = shadow_reg[eepc_pkg::OPT_BP_LSB +: eepc_pkg::BLOCKS];
  assign mode = eepc_pkg::eepc_mode_type'(
    ctrl_reg[eepc_pkg::CTRL_ERASE_LO +: 2]);

  // a secure byte is no valid target once permanent protect is on
  assign valid_arr_wr = wr_take && latch && in_array(avs_address_in)
    && !(perm_on && in_secure(avs_address_in));
  assign valid_nv_wr = wr_take && latch
    && (avs_address_in == eepc_pkg::REG_NVOPT) && !perm_on;
  assign wr_ctrl = wr_take && (avs_address_in == eepc_pkg::REG_CTRL);
  assign ctrl_open = !latch || valid_reg;

  // protection of the latched target in the selected mode
  always_comb begin
    prot = 1'b0;
    if (lat_nv_reg) begin
      prot = perm_on || (mode == eepc_pkg::MODE_BLOCK_ERASE)
        || (mode == eepc_pkg::MODE_BULK_ERASE);
    end else begin
      case (mode)
        eepc_pkg::MODE_BYTE_PROG, eepc_pkg::MODE_BYTE_ERASE:
          prot = bp[block_of(lat_idx_reg)];
        eepc_pkg::MODE_BLOCK_ERASE:
          prot = bp[block_of(lat_idx_reg)] || perm_on;
        eepc_pkg::MODE_BULK_ERASE:
          prot = (|bp) || perm_on;
        default: prot = 1'b1;
      endcase
    end
  end

  // stop removes the voltage; it returns by itself when stop ends
  assign hv_apply = hv && latch && valid_reg && !prot
    && !stop_in;

  // next control value for a software write
  always_comb begin
    ctrl_next = wdata & eepc_pkg::CTRL_MASK;
    // set only with latch set and a valid write behind it
    ctrl_next[eepc_pkg::CTRL_HV] = wdata[eepc_pkg::CTRL_HV]
      && latch && valid_reg;
    // the latch stays while the voltage enable was set
    ctrl_next[eepc_pkg::CTRL_LATCH] = wdata[eepc_pkg::CTRL_LATCH]
      || hv;
    // the mode is frozen while the voltage is enabled
    if (hv) begin
      ctrl_next[eepc_pkg::CTRL_ERASE_LO +: 2] =
        ctrl_reg[eepc_pkg::CTRL_ERASE_LO +: 2];
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_reg <= eepc_pkg::CTRL_RESET;
    end else if (ce_in && wr_ctrl && ctrl_open) begin
      ctrl_reg <= ctrl_next;
    end
  end

  // latched address and data; later valid writes overwrite them
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lat_idx_reg <= '0;
      lat_nv_reg <= 1'b0;
      lat_data_reg <= '0;
      valid_reg <= 1'b0;
    end else if (ce_in) begin
      if (valid_arr_wr || valid_nv_wr) begin
        lat_idx_reg <= addr_idx;
        lat_nv_reg <= valid_nv_wr;
        lat_data_reg <= wdata;
        valid_reg <= 1'b1;
      end else if (!latch) begin
        valid_reg <= 1'b0;
      end
    end
  end

  eepc_pump #(
    .PGM_TICKS(PGM_TICKS)
  ) u_pump (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .rc_osc_in(rc_osc_in),
    .use_bus_clk_in(ctrl_reg[eepc_pkg::CTRL_PUMP_CLK]),
    .hv_apply_in(hv_apply),
    .hv_clear_in(!hv),
    .op_go_out(op_go)
  );

  assign arr.rd_addr = addr_idx;
  assign arr.op_go = op_go && !lat_nv_reg;
  assign arr.op_mode = mode;
  assign arr.op_addr = lat_idx_reg;
  assign arr.op_data = lat_data_reg;

  eepc_array u_array (
    .core_clk_in(core_clk_in),
    .ce_in(ce_in),
    .arr(arr)
  );

  // program or erase of the option byte; its protect bit never rises
  always_comb begin
    if (mode == eepc_pkg::MODE_BYTE_PROG) begin
      nv_result = nvopt_reg & lat_data_reg;
    end else begin
      nv_result = eepc_pkg::ERASED_BYTE;
    end
    nv_result[eepc_pkg::OPT_PERM] = nvopt_reg[eepc_pkg::OPT_PERM]
      & nv_result[eepc_pkg::OPT_PERM];
  end

  // model of the nonvolatile byte: reset gives the factory value
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      nvopt_reg <= eepc_pkg::NV_FACTORY;
    end else if (ce_in && op_go && lat_nv_reg) begin
      nvopt_reg <= nv_result;
    end
  end

  // shadow loads after reset release and on every option byte read
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shadow_reg <= eepc_pkg::SHADOW_RESET;
      load_pend_reg <= 1'b1;
    end else if (ce_in) begin
      load_pend_reg <= 1'b0;
      if (load_pend_reg || (rd_take
          && avs_address_in == eepc_pkg::REG_NVOPT)) begin
        shadow_reg <= nvopt_reg;
      end else if (wr_take
          && avs_address_in == eepc_pkg::REG_SHADOW) begin
        shadow_reg <= wdata;
        shadow_reg[eepc_pkg::OPT_PERM] <= shadow_reg[eepc_pkg::OPT_PERM]
          & wdata[eepc_pkg::OPT_PERM];
      end
    end
  end

  // sticky until the latch drops: an operation was refused by protection
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      blocked_reg <= 1'b0;
    end else if (ce_in) begin
      if (hv && latch && valid_reg && prot) begin
        blocked_reg <= 1'b1;
      end else if (!latch) begin
        blocked_reg <= 1'b0;
      end
    end
  end

  // read data for the addressed location
  always_comb begin
    rd_byte = '0;
    if (ctrl_reg[eepc_pkg::CTRL_POWER_DOWN]) begin
      rd_byte = eepc_pkg::ARRAY_OFF_DATA;
    end else if (latch) begin
      rd_byte = lat_data_reg;
    end else begin
      rd_byte = arr.rd_data;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      readdata_reg <= eepc_pkg::UNMAPPED_DATA;
    end else if (ce_in && rd_take) begin
      readdata_reg <= eepc_pkg::UNMAPPED_DATA;
      if (in_array(avs_address_in)) begin
        readdata_reg[7:0] <= rd_byte;
      end else begin
        case (avs_address_in)
          eepc_pkg::REG_CTRL: readdata_reg[7:0] <= ctrl_reg;
          eepc_pkg::REG_NVOPT: readdata_reg[7:0] <= nvopt_reg;
          eepc_pkg::REG_SHADOW: readdata_reg[7:0] <= shadow_reg;
          eepc_pkg::REG_STATUS: begin
            readdata_reg[eepc_pkg::STAT_HV_ON] <= hv_on_out;
            readdata_reg[eepc_pkg::STAT_VALID] <= valid_reg;
            readdata_reg[eepc_pkg::STAT_STOP] <= stop_in;
            readdata_reg[eepc_pkg::STAT_BLOCKED] <= blocked_reg;
          end
          default: ;
        endcase
      end
    end
  end

  // every access answers in the cycle after it is taken
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_state_reg <= BUS_IDLE;
    end else if (ce_in) begin
      case (bus_state_reg)
        BUS_IDLE: begin
          if (req_take) begin
            bus_state_reg <= BUS_ANSWER;
          end
        end
        BUS_ANSWER: bus_state_reg <= BUS_IDLE;
        default: bus_state_reg <= BUS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (ce_in) begin
      avs_waitrequest_out <= !req_take;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hv_on_out <= 1'b0;
      pump_bus_clock_out <= 1'b0;
      array_power_down_out <= 1'b0;
      config_out <= '0;
    end else if (ce_in) begin
      hv_on_out <= hv_apply;
      pump_bus_clock_out <= ctrl_reg[eepc_pkg::CTRL_PUMP_CLK];
      array_power_down_out <= ctrl_reg[eepc_pkg::CTRL_POWER_DOWN];
      config_out <= shadow_reg[eepc_pkg::OPT_CONFIG_LSB +: 2];
    end
  end

  assign avs_readdata_out = readdata_reg;
endmodule // eepc_top
`default_nettype wire

// >>> hw/eepc_pkg.sv
// eepc_pkg: shared constants and types of the eeprom program/erase control
package eepc_pkg;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 9;
  // register word indices (byte address is four times these)
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_NVOPT = 12'h001;
  localparam logic [11:0] REG_SHADOW = 12'h002;
  localparam logic [11:0] REG_STATUS = 12'h003;
  // array window and secure range
  localparam logic [11:0] ARRAY_BASE = 12'h800;
  localparam logic [11:0] ARRAY_LAST = 12'h9ff;
  localparam logic [11:0] SECURE_FIRST = 12'h8f0;
  localparam logic [11:0] SECURE_LAST = 12'h8ff;
  localparam int BLOCK_SHIFT = 7;
  localparam int BLOCKS = 4;
  // control register fields
  localparam int CTRL_PUMP_CLK = 7;
  localparam int CTRL_POWER_DOWN = 5;
  localparam int CTRL_ERASE_HI = 4;
  localparam int CTRL_ERASE_LO = 3;
  localparam int CTRL_LATCH = 2;
  localparam int CTRL_HV = 0;
  localparam logic [7:0] CTRL_MASK = 8'hbd;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // option byte and shadow fields
  localparam int OPT_RESERVED = 7;
  localparam int OPT_CONFIG_LSB = 5;
  localparam int OPT_PERM = 4;
  localparam int OPT_BP_LSB = 0;
  localparam logic [7:0] NV_FACTORY = 8'h10;
  localparam logic [7:0] SHADOW_RESET = 8'h10;
  // status register fields
  localparam int STAT_HV_ON = 0;
  localparam int STAT_VALID = 1;
  localparam int STAT_STOP = 2;
  localparam int STAT_BLOCKED = 3;
  // data constants
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] ARRAY_OFF_DATA = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef enum logic [1:0] {
    MODE_BYTE_PROG,
    MODE_BYTE_ERASE,
    MODE_BLOCK_ERASE,
    MODE_BULK_ERASE
  } eepc_mode_type;
endpackage

// >>> hw/eepc_arr_if.sv
// eepc_arr_if: read port and operation strobe between control and array
`timescale 1ns/1ps
`default_nettype none
interface eepc_arr_if;
  logic [8:0] rd_addr;
  logic [7:0] rd_data;
  logic op_go;
  eepc_pkg::eepc_mode_type op_mode;
  logic [8:0] op_addr;
  logic [7:0] op_data;
  modport ctrl (output rd_addr, op_go, op_mode, op_addr, op_data,
    input rd_data);
  modport mem (input rd_addr, op_go, op_mode, op_addr, op_data,
    output rd_data);
endinterface
`default_nettype wire

// >>> hw/eepc_array.sv
// eepc_array: the 512 byte cell array with program and erase operations
`timescale 1ns/1ps
`default_nettype none
module eepc_array (
  input wire logic core_clk_in,
  input wire logic ce_in,
  eepc_arr_if.mem arr
);
  // cells hold their contents through reset, like real storage
  logic [7:0] cell_mem [512];
  logic [1:0] op_blk;
  assign op_blk = arr.op_addr[8:7];
  assign arr.rd_data = cell_mem[arr.rd_addr];

  always_ff @(posedge core_clk_in) begin
    if (ce_in && arr.op_go) begin
      case (arr.op_mode)
        eepc_pkg::MODE_BYTE_PROG:
          cell_mem[arr.op_addr] <= cell_mem[arr.op_addr] & arr.op_data;
        eepc_pkg::MODE_BYTE_ERASE:
          cell_mem[arr.op_addr] <= eepc_pkg::ERASED_BYTE;
        eepc_pkg::MODE_BLOCK_ERASE: begin
          for (int i = 0; i < 512; i++) begin
            if (i[8:7] == op_blk) begin
              cell_mem[i] <= eepc_pkg::ERASED_BYTE;
            end
          end
        end
        eepc_pkg::MODE_BULK_ERASE: begin
          for (int i = 0; i < 512; i++) begin
            cell_mem[i] <= eepc_pkg::ERASED_BYTE;
          end
        end
        default: ;
      endcase
    end
  end
endmodule // eepc_array
`default_nettype wire

// >>> hw/eepc_pump.sv
// eepc_pump: charge pump clock choice and program/erase duration count
`timescale 1ns/1ps
`default_nettype none
module eepc_pump #(
  parameter int PGM_TICKS = 64
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic rc_osc_in,
  input wire logic use_bus_clk_in,
  input wire logic hv_apply_in,
  input wire logic hv_clear_in,
  output logic op_go_out
);
  localparam int CW = $clog2(PGM_TICKS + 1);
  localparam logic [CW-1:0] LAST = CW'(PGM_TICKS - 1);
  if (PGM_TICKS < 1) begin : g_bad_ticks
    $error("eepc_pump: PGM_TICKS must be at least 1");
  end
  logic rc_meta_reg, rc_sync_reg, rc_prev_reg;
  logic [CW-1:0] count_reg;
  logic done_reg;
  logic tick;

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rc_meta_reg <= 1'b0;
      rc_sync_reg <= 1'b0;
      rc_prev_reg <= 1'b0;
    end else if (ce_in) begin
      rc_meta_reg <= rc_osc_in;
      rc_sync_reg <= rc_meta_reg;
      rc_prev_reg <= rc_sync_reg;
    end
  end

  // bus clock ticks every cycle, the rc oscillator on its rising edge
  assign tick = use_bus_clk_in | (rc_sync_reg & ~rc_prev_reg);

  // count holds while high voltage is off in stop, so the time stretches
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_reg <= '0;
      done_reg <= 1'b0;
      op_go_out <= 1'b0;
    end else if (ce_in) begin
      op_go_out <= 1'b0;
      if (hv_clear_in) begin
        count_reg <= '0;
        done_reg <= 1'b0;
      end else if (hv_apply_in && tick && !done_reg) begin
        if (count_reg == LAST) begin
          done_reg <= 1'b1;
          op_go_out <= 1'b1;
        end else begin
          count_reg <= count_reg + CW'(1);
        end
      end
    end
  end
endmodule // eepc_pump
`default_nettype wire

// >>> testbench/eepc_top_props.sv
// eepc_top_props: concurrent checks on the eepc_top ports
`timescale 1ns/1ps
`default_nettype none
module eepc_top_props (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic stop_in,
  input wire logic hv_on_out,
  input wire logic pump_bus_clock_out,
  input wire logic array_power_down_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // answer cycle of a control write; the copy outputs move one edge later
  logic ctrl_wr_ans;
  assign ctrl_wr_ans = !avs_waitrequest_out && avs_write_in
    && avs_address_in == eepc_pkg::REG_CTRL;
  chk_wait_pulse:
    assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  chk_answer_cause:
    assert property ($fell(avs_waitrequest_out) |->
      avs_read_in || avs_write_in)
    else $error("answer without a request");
  chk_read_upper:
    assert property (avs_readdata_out[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  chk_read_hold:
    assert property ($changed(avs_readdata_out) |->
      !avs_waitrequest_out && avs_read_in)
    else $error("read data moved outside a read answer");
  chk_pump_copy:
    assert property ($changed(pump_bus_clock_out) |-> $past(ctrl_wr_ans)
      && pump_bus_clock_out
      == $past(avs_writedata_in[eepc_pkg::CTRL_PUMP_CLK]))
    else $error("pump select moved without control write");
  chk_power_copy:
    assert property ($changed(array_power_down_out) |-> $past(ctrl_wr_ans)
      && array_power_down_out
      == $past(avs_writedata_in[eepc_pkg::CTRL_POWER_DOWN]))
    else $error("power down moved without control write");
  chk_stop_drops_hv:
    assert property (stop_in [*3] |-> !hv_on_out)
    else $error("high voltage kept during stop");
  chk_hv_rise_clear:
    assert property ($rose(hv_on_out) |-> !stop_in && !$past(stop_in))
    else $error("high voltage rose while stopped");
  // mid-run reset too: outputs come back cleared
  chk_reset_clears:
    assert property (disable iff (1'b0) $rose(rstn_in) |->
      !hv_on_out && !pump_bus_clock_out && !array_power_down_out)
    else $error("outputs not cleared by reset");
endmodule // eepc_top_props
bind eepc_top eepc_top_props u_props (.*);
`default_nettype wire

// >>> testbench/test_eepc_top.sv
// test_eepc_top: self-checking bench for the eeprom program/erase control
`timescale 1ns/1ps
`default_nettype none
module test_eepc_top;
  localparam int TICKS = 4;
  logic core_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic [11:0] avs_address_in = 12'h000;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic rc_osc_in = 1'b0;
  logic stop_in = 1'b0;
  logic hv_on_out;
  logic pump_bus_clock_out;
  logic array_power_down_out;
  logic [1:0] config_out;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic [1:0] rc_cnt = 2'h0;
  logic [11:0] a0;
  logic [7:0] d0;
  int err_total = 0;
  int comparisons = 0;
  int seed = 72;
  int b;
  eepc_top #(.PGM_TICKS(TICKS)) dut (
    .core_clk_in(core_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .rc_osc_in(rc_osc_in),
    .stop_in(stop_in), .hv_on_out(hv_on_out),
    .pump_bus_clock_out(pump_bus_clock_out),
    .array_power_down_out(array_power_down_out), .config_out(config_out));
  always #5 core_clk_in = ~core_clk_in;
  // slow oscillator: a pump tick every six bus cycles
  always @(posedge core_clk_in) begin
    rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    if (rc_cnt == 2'h2) rc_osc_in <= ~rc_osc_in;
  end
  task automatic print_verdict();
    // a read whose answer never came counts as a mismatch
    if (exp_q.size() != 0) begin
      err_total++;
    end
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one avalon access; clock enable may hold off the first edge
  task automatic bus(input logic wr, input logic [11:0] adr,
      input logic [7:0] dat);
    int i;
    @(posedge core_clk_in);
    ce_in <= ($random(seed) % 3) != 0;
    avs_address_in <= adr;
    avs_writedata_in <= {24'h0, dat};
    avs_write_in <= wr;
    avs_read_in <= !wr;
    // waitrequest is a register: read here, it holds what this edge saw
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk_in);
      ce_in <= 1'b1;
      if (avs_waitrequest_out === 1'b0) break;
    end
    if (i == 50) begin
      err_total++;
      print_verdict();
    end else begin
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] adr, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, adr, 8'h00);
  endtask
  // read results are matched against the oldest note
  always @(posedge core_clk_in) begin
    if (rstn_in && avs_read_in && avs_waitrequest_out === 1'b0) begin
      exp_v = exp_q.pop_front();
      cmp(avs_readdata_out, exp_v);
    end
  end
  task automatic op(input logic [1:0] m, input logic [11:0] adr,
      input logic [7:0] dat, input logic hv, input logic st);
    logic [7:0] c;
    c = {3'h0, m, 3'h4};
    bus(1'b1, eepc_pkg::REG_CTRL, c);
    bus(1'b1, eepc_pkg::REG_CTRL, c | 8'h80);
    rd(eepc_pkg::REG_CTRL, {24'h0, c});
    bus(1'b1, adr ^ 12'h001, ~dat);
    bus(1'b1, adr, dat);
    if (hv) rd(adr ^ 12'h002, {24'h0, dat});
    bus(1'b1, eepc_pkg::REG_CTRL, c | 8'h01);
    repeat (4) @(negedge core_clk_in);
    cmp(hv_on_out, hv);
    if (hv) begin
      bus(1'b1, eepc_pkg::REG_CTRL, {3'h0, m, 3'h1});
      rd(eepc_pkg::REG_CTRL, {24'h0, c | 8'h01});
    end
    if (st) begin
      @(posedge core_clk_in);
      stop_in <= 1'b1;
      repeat (5) @(negedge core_clk_in);
      cmp(hv_on_out, 1'b0);
      rd(eepc_pkg::REG_CTRL, {24'h0, c | 8'h01});
      @(posedge core_clk_in);
      stop_in <= 1'b0;
      repeat (4) @(negedge core_clk_in);
      cmp(hv_on_out, 1'b1);
    end
    repeat (80) @(posedge core_clk_in);
    bus(1'b1, eepc_pkg::REG_CTRL, c & 8'hfa);
    rd(eepc_pkg::REG_CTRL, {24'h0, c});
    cmp(hv_on_out, 1'b0);
    bus(1'b1, eepc_pkg::REG_CTRL, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(negedge core_clk_in);
    cmp({hv_on_out, pump_bus_clock_out, array_power_down_out}, 0);
    rd(eepc_pkg::REG_CTRL, 32'h0);
    rd(eepc_pkg::REG_NVOPT, {24'h0, eepc_pkg::NV_FACTORY});
    rd(eepc_pkg::REG_SHADOW, {24'h0, eepc_pkg::SHADOW_RESET});
    bus(1'b1, 12'h7ff, 8'hff);
    rd(12'h7ff, eepc_pkg::UNMAPPED_DATA);
    bus(1'b1, eepc_pkg::REG_CTRL, 8'ha0);
    rd(eepc_pkg::REG_CTRL, 32'ha0);
    cmp({pump_bus_clock_out, array_power_down_out}, 2'b11);
    rd(eepc_pkg::ARRAY_BASE, {24'h0, eepc_pkg::ARRAY_OFF_DATA});
    bus(1'b1, eepc_pkg::REG_CTRL, 8'h00);
    @(negedge core_clk_in);
    cmp({pump_bus_clock_out, array_power_down_out}, 2'b00);
    bus(1'b1, eepc_pkg::REG_SHADOW, 8'h70);
    @(negedge core_clk_in);
    cmp(config_out, 2'b11);
    rd(eepc_pkg::REG_NVOPT, {24'h0, eepc_pkg::NV_FACTORY});
    rd(eepc_pkg::REG_SHADOW, {24'h0, eepc_pkg::NV_FACTORY});
    cmp(config_out, 2'b00);
    a0 = eepc_pkg::ARRAY_BASE + (12'($random(seed)) & 12'h07f);
    d0 = 8'($random(seed));
    op(eepc_pkg::MODE_BYTE_ERASE, a0, d0, 1'b1, 1'b0);
    rd(a0, {24'h0, eepc_pkg::ERASED_BYTE});
    op(eepc_pkg::MODE_BYTE_PROG, a0, d0, 1'b1, 1'b1);
    rd(a0, {24'h0, d0});
    op(eepc_pkg::MODE_BLOCK_ERASE, 12'h940, d0, 1'b1, 1'b0);
    rd(12'h97f, {24'h0, eepc_pkg::ERASED_BYTE});
    op(eepc_pkg::MODE_BULK_ERASE, 12'h9ff, d0, 1'b1, 1'b0);
    rd(a0, {24'h0, eepc_pkg::ERASED_BYTE});
    // each block: its first byte locked, the last byte of the block before (block 3 for block 0) still open
    for (b = 0; b < 4; b++) begin
      bus(1'b1, eepc_pkg::REG_SHADOW, 8'h10 | (8'h01 << b));
      op(eepc_pkg::MODE_BYTE_ERASE, eepc_pkg::ARRAY_BASE + 12'(b * 128),
        d0, 1'b0, 1'b0);
      op(eepc_pkg::MODE_BYTE_ERASE,
        eepc_pkg::ARRAY_BASE + 12'(((b + 3) % 4) * 128 + 127),
        d0, 1'b1, 1'b0);
    end
    bus(1'b1, eepc_pkg::REG_SHADOW, 8'h00);
    bus(1'b1, eepc_pkg::REG_SHADOW, 8'h10);
    rd(eepc_pkg::REG_SHADOW, 32'h0);
    op(eepc_pkg::MODE_BYTE_ERASE, eepc_pkg::SECURE_FIRST - 12'h001,
      d0, 1'b1, 1'b0);
    // a refused secure write can leave the latch stuck: reset recovers
    bus(1'b1, eepc_pkg::REG_CTRL, 8'h04);
    bus(1'b1, eepc_pkg::SECURE_LAST, d0);
    bus(1'b1, eepc_pkg::REG_CTRL, 8'h05);
    repeat (4) @(negedge core_clk_in);
    cmp(hv_on_out, 1'b0);
    @(posedge core_clk_in);
    rstn_in <= 1'b0;
    repeat (8) @(posedge core_clk_in);
    rstn_in <= 1'b1;
    @(negedge core_clk_in);
    cmp({hv_on_out, pump_bus_clock_out, array_power_down_out}, 0);
    rd(eepc_pkg::REG_CTRL, 32'h0);
    @(negedge core_clk_in);
    print_verdict();
  end
endmodule // test_eepc_top
`default_nettype wire
